// >>> pkg/fosc_pkg.sv
package fosc_pkg;
  localparam int ADDR_W = 24;
  localparam int SECT_LSB = 17;
  localparam int NSECT = 128;
  localparam int SECT_W = 7;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR = 24'h000555;
  localparam logic [ADDR_W-1:0] EXIT_ADDR = 24'h000000;
  localparam logic [ADDR_W-1:0] CRC_LO_ADDR = 24'h000000;
  localparam logic [ADDR_W-1:0] CRC_HI_ADDR = 24'h000001;
  localparam logic [ADDR_W-1:0] SSR_LIMIT = 24'h000200;
  localparam logic [15:0] CMD_QUERY = 16'h0098;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_STATUS = 16'h0070;
  localparam logic [15:0] CMD_SSR = 16'h0088;
  localparam logic [15:0] CMD_CFG = 16'h0040;
  localparam logic [15:0] CMD_PWD = 16'h0060;
  localparam logic [15:0] CMD_PROT = 16'h00c0;
  localparam logic [15:0] CMD_LOCK = 16'h0050;
  localparam logic [15:0] CMD_CRC = 16'h0078;
  localparam logic [15:0] CMD_PROG = 16'h00a0;
  localparam logic [15:0] CMD_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_UNLOCK = 16'h0025;
  localparam logic [15:0] CMD_BULK = 16'h0030;
  localparam logic [15:0] CMD_CRC_START = 16'h00c3;
  localparam logic [15:0] CFG_RESET = 16'hffff;
  localparam logic [15:0] UNDEF_DATA = 16'hffff;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  typedef enum logic [3:0] {
    FOSC_ARRAY = 4'h0, FOSC_QUERY = 4'h1, FOSC_STATUS = 4'h2,
    FOSC_SSR = 4'h3, FOSC_CFG = 4'h4, FOSC_PWD = 4'h5,
    FOSC_PROT = 4'h6, FOSC_LOCK = 4'h7, FOSC_CRC = 4'h8
  } fosc_map_t;
  typedef enum logic [1:0] {
    FOSC_CRC_IDLE = 2'b00, FOSC_CRC_RUN = 2'b01
  } fosc_crc_t;
endpackage

// >>> logic/fosc_overlay.sv
// Overlay selector: decodes bus commands and chooses read data source.
module fosc_overlay (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Memory bus command/read side
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_burst_first,
  input wire logic [fosc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  // Array and side-store read data
  input wire logic [15:0] array_rdata,
  input wire logic [15:0] query_rdata,
  input wire logic [15:0] ssr_rdata,
  input wire logic [7:0] device_status,
  // CRC range and array fetch
  input wire logic [fosc_pkg::ADDR_W-1:0] crc_start,
  input wire logic [fosc_pkg::ADDR_W-1:0] crc_end,
  output logic crc_fetch,
  output logic [fosc_pkg::ADDR_W-1:0] crc_addr,
  input wire logic [15:0] crc_fetch_data,
  // Program requests to the side stores
  output logic ssr_prog,
  output logic [fosc_pkg::ADDR_W-1:0] prog_addr,
  output logic [15:0] prog_data,
  // State visible outside
  output logic [3:0] active_map,
  output logic global_protect_lock_bit,
  output logic [15:0] protection_configuration_register
);
  fosc_pkg::fosc_map_t map, next_map, saved_map, next_saved_map;
  logic [fosc_pkg::SECT_W-1:0] sector_sel, next_sector_sel;
  logic [7:0] status_cap, next_status_cap;
  logic prog_armed, next_prog_armed;
  logic [15:0] next_cfg;
  logic [15:0] pwd [4];
  logic [15:0] next_pwd [4];
  logic [fosc_pkg::NSECT-1:0] prot, next_prot;
  logic next_lock;
  logic [15:0] rdata, next_rdata;
  logic ssr_prog_r, next_ssr_prog;
  logic [fosc_pkg::ADDR_W-1:0] paddr, next_paddr;
  logic [15:0] pdata, next_pdata;
  fosc_pkg::fosc_crc_t crc_st, next_crc_st;
  logic [31:0] crc, next_crc, crc_res, next_crc_res;
  logic [fosc_pkg::ADDR_W-1:0] caddr, next_caddr;
  logic cfetch, next_cfetch;
  logic [fosc_pkg::SECT_W-1:0] rd_sect;
  logic rd_in_sect;

  assign rd_sect = bus_addr[fosc_pkg::SECT_LSB +: fosc_pkg::SECT_W];
  assign rd_in_sect = (rd_sect == sector_sel);

  // CRC step over one 16-bit word, MSB first
  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [15:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ fosc_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Command decode and overlay store updates
  always_comb begin
    next_map = map;
    next_saved_map = saved_map;
    next_sector_sel = sector_sel;
    next_status_cap = status_cap;
    next_prog_armed = 1'b0;
    next_cfg = protection_configuration_register;
    next_pwd = pwd;
    next_prot = prot;
    next_lock = global_protect_lock_bit;
    next_ssr_prog = 1'b0;
    next_paddr = paddr;
    next_pdata = pdata;
    if (bus_wr) begin
      if (bus_wdata == fosc_pkg::CMD_RESET) begin
        next_map = fosc_pkg::FOSC_ARRAY;
      end else if (bus_wdata == fosc_pkg::CMD_STATUS) begin
        // Capture now so a later status change cannot tear the read
        next_status_cap = device_status;
        if (map != fosc_pkg::FOSC_STATUS) begin
          next_saved_map = map;
        end
        next_map = fosc_pkg::FOSC_STATUS;
      end else if (prog_armed) begin
        // Second cycle of a modified word program: address plus data
        unique case (map)
          fosc_pkg::FOSC_SSR: begin
            next_ssr_prog = 1'b1;
            next_paddr = bus_addr;
            next_pdata = bus_wdata;
          end
          fosc_pkg::FOSC_CFG: next_cfg = bus_wdata;
          fosc_pkg::FOSC_PWD: begin
            next_pwd[bus_addr[1:0]] = bus_wdata;
          end
          fosc_pkg::FOSC_PROT: next_prot[rd_sect] = 1'b1;
          fosc_pkg::FOSC_LOCK: next_lock = 1'b0;
          default: next_map = map;
        endcase
      end else if (map == fosc_pkg::FOSC_ARRAY) begin
        // Entry only from the array map keeps one overlay at a time
        if (bus_addr == fosc_pkg::UNLOCK_ADDR) begin
          next_sector_sel = rd_sect;
          unique case (bus_wdata)
            fosc_pkg::CMD_QUERY: next_map = fosc_pkg::FOSC_QUERY;
            fosc_pkg::CMD_SSR: next_map = fosc_pkg::FOSC_SSR;
            fosc_pkg::CMD_CFG: next_map = fosc_pkg::FOSC_CFG;
            fosc_pkg::CMD_PWD: next_map = fosc_pkg::FOSC_PWD;
            fosc_pkg::CMD_PROT: next_map = fosc_pkg::FOSC_PROT;
            fosc_pkg::CMD_LOCK: next_map = fosc_pkg::FOSC_LOCK;
            fosc_pkg::CMD_CRC: next_map = fosc_pkg::FOSC_CRC;
            default: next_map = map;
          endcase
        end
      end else if (bus_wdata == fosc_pkg::CMD_PROG) begin
        next_prog_armed = 1'b1;
      end else if (bus_wdata == fosc_pkg::CMD_EXIT1 ||
                   bus_wdata == fosc_pkg::CMD_EXIT2) begin
        if (map != fosc_pkg::FOSC_QUERY) begin
          next_map = fosc_pkg::FOSC_ARRAY;
        end
      end else if (bus_wdata == fosc_pkg::CMD_BULK &&
                   map == fosc_pkg::FOSC_PROT) begin
        next_prot = '0;
      end else if (bus_wdata == fosc_pkg::CMD_UNLOCK &&
                   map == fosc_pkg::FOSC_PWD) begin
        // Unlock succeeds only when the offered word matches word 0
        if (bus_addr[15:0] == pwd[0]) begin
          next_lock = 1'b0;
        end
      end
    end else if (bus_rd && map == fosc_pkg::FOSC_STATUS) begin
      next_map = saved_map;
    end
  end

  // Read data mux; sector and offset checks pick overlay or array
  always_comb begin
    next_rdata = rdata;
    if (bus_rd) begin
      unique case (map)
        fosc_pkg::FOSC_ARRAY: next_rdata = array_rdata;
        fosc_pkg::FOSC_QUERY:
          next_rdata = rd_in_sect ? query_rdata : array_rdata;
        fosc_pkg::FOSC_STATUS:
          next_rdata = bus_burst_first ? {8'h00, status_cap}
                                       : fosc_pkg::UNDEF_DATA;
        fosc_pkg::FOSC_SSR: begin
          if (!rd_in_sect) begin
            next_rdata = array_rdata;
          end else if (bus_addr[fosc_pkg::SECT_LSB-1:0] <
                       fosc_pkg::SSR_LIMIT[fosc_pkg::SECT_LSB-1:0]) begin
            next_rdata = ssr_rdata;
          end else begin
            next_rdata = fosc_pkg::UNDEF_DATA;
          end
        end
        fosc_pkg::FOSC_CFG:
          next_rdata = (bus_addr == fosc_pkg::EXIT_ADDR)
                       ? protection_configuration_register
                       : fosc_pkg::UNDEF_DATA;
        fosc_pkg::FOSC_PWD:
          next_rdata = (bus_addr[fosc_pkg::ADDR_W-1:2] == '0)
                       ? pwd[bus_addr[1:0]] : fosc_pkg::UNDEF_DATA;
        fosc_pkg::FOSC_PROT:
          next_rdata = {15'h0000, prot[rd_sect]};
        fosc_pkg::FOSC_LOCK:
          next_rdata = {15'h0000, global_protect_lock_bit};
        fosc_pkg::FOSC_CRC:
          next_rdata = (bus_addr == fosc_pkg::CRC_HI_ADDR)
                       ? crc_res[31:16] : crc_res[15:0];
        default: next_rdata = fosc_pkg::UNDEF_DATA;
      endcase
    end
  end

  // CRC engine walks start..end inclusive, one word per fetch
  always_comb begin
    next_crc_st = crc_st;
    next_crc = crc;
    next_crc_res = crc_res;
    next_caddr = caddr;
    next_cfetch = 1'b0;
    unique case (crc_st)
      fosc_pkg::FOSC_CRC_IDLE: begin
        if (bus_wr && map == fosc_pkg::FOSC_CRC &&
            bus_wdata == fosc_pkg::CMD_CRC_START) begin
          next_crc_st = fosc_pkg::FOSC_CRC_RUN;
          next_crc = fosc_pkg::CRC_INIT;
          next_caddr = crc_start;
          next_cfetch = 1'b1;
        end
      end
      fosc_pkg::FOSC_CRC_RUN: begin
        // Store answers while the strobe stands; cycles without it only raise it again
        if (cfetch) begin
          next_crc = crc_word(crc, crc_fetch_data);
          if (caddr == crc_end) begin
            next_crc_res = crc_word(crc, crc_fetch_data);
            next_crc_st = fosc_pkg::FOSC_CRC_IDLE;
          end else begin
            next_caddr = caddr + 1'b1;
          end
        end else begin
          next_cfetch = 1'b1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      map <= fosc_pkg::FOSC_ARRAY;
      saved_map <= fosc_pkg::FOSC_ARRAY;
      sector_sel <= '0;
      status_cap <= '0;
      prog_armed <= 1'b0;
      protection_configuration_register <= fosc_pkg::CFG_RESET;
      for (int i = 0; i < 4; i++) begin
        pwd[i] <= fosc_pkg::UNDEF_DATA;
      end
      prot <= '0;
      global_protect_lock_bit <= 1'b1;
      rdata <= '0;
      ssr_prog_r <= 1'b0;
      paddr <= '0;
      pdata <= '0;
      crc_st <= fosc_pkg::FOSC_CRC_IDLE;
      crc <= '0;
      crc_res <= '0; // Volatile: cleared by reset
      caddr <= '0;
      cfetch <= 1'b0;
    end else begin
      map <= next_map;
      saved_map <= next_saved_map;
      sector_sel <= next_sector_sel;
      status_cap <= next_status_cap;
      prog_armed <= next_prog_armed;
      protection_configuration_register <= next_cfg;
      pwd <= next_pwd;
      prot <= next_prot;
      global_protect_lock_bit <= next_lock;
      rdata <= next_rdata;
      ssr_prog_r <= next_ssr_prog;
      paddr <= next_paddr;
      pdata <= next_pdata;
      crc_st <= next_crc_st;
      crc <= next_crc;
      crc_res <= next_crc_res;
      caddr <= next_caddr;
      cfetch <= next_cfetch;
    end
  end

  assign bus_rdata = rdata;
  assign active_map = map;
  assign ssr_prog = ssr_prog_r;
  assign prog_addr = paddr;
  assign prog_data = pdata;
  assign crc_fetch = cfetch;
  assign crc_addr = caddr;
endmodule // fosc_overlay

// >>> sim/fosc_checker.sv
module fosc_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bus side
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [fosc_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic [15:0] array_rdata,
  input wire logic [7:0] device_status,
  // Visible state
  input wire logic [3:0] active_map,
  input wire logic global_protect_lock_bit,
  input wire logic [15:0] protection_configuration_register
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Entry only counts from the array map
  property p_query_in;
    active_map == 4'h0 && bus_wr && bus_addr == fosc_pkg::UNLOCK_ADDR &&
      bus_wdata == fosc_pkg::CMD_QUERY |=> active_map == 4'h1;
  endproperty
  a_query_in: assert property (p_query_in)
    else $error("query entry not taken");
  // Status is left out here, though reset also returns it to the array
  property p_reset;
    bus_wr && bus_wdata == fosc_pkg::CMD_RESET && active_map != 4'h2
      |=> active_map == 4'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset command did not return to array");
  // Apart from a status command, an overlay may only stay or fall back to the array
  property p_nojump;
    active_map inside {[4'h3:4'h7]} && bus_wr &&
      bus_wdata != fosc_pkg::CMD_STATUS
      |=> active_map == $past(active_map) || active_map == 4'h0;
  endproperty
  a_nojump: assert property (p_nojump)
    else $error("overlay changed without exit");
  // Status word is the value seen when the command landed
  property p_status_rd;
    bus_wr && bus_wdata == fosc_pkg::CMD_STATUS ##1
      (bus_rd && active_map == 4'h2)
      |=> bus_rdata == {8'h00, $past(device_status, 2)};
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status word wrong");
  property p_status_exit;
    active_map == 4'h2 && bus_rd |=> active_map != 4'h2;
  endproperty
  a_status_exit: assert property (p_status_exit)
    else $error("status overlay kept after read");
  property p_array;
    active_map == 4'h0 && bus_rd |=> bus_rdata == $past(array_rdata);
  endproperty
  a_array: assert property (p_array)
    else $error("array read wrong");
  property p_cfg_rd;
    active_map == 4'h4 && bus_rd && bus_addr == '0
      |=> bus_rdata == $past(protection_configuration_register);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("config word wrong");
  property p_lock_rd;
    active_map == 4'h7 && bus_rd
      |=> bus_rdata[0] == $past(global_protect_lock_bit);
  endproperty
  a_lock_rd: assert property (p_lock_rd)
    else $error("lock bit read wrong");
  // Main scenarios reached
  c_status: cover property (bus_wr ##1 (bus_rd && active_map == 4'h2));
  c_crc: cover property (active_map == 4'h8);
  c_lock_clr: cover property ($fell(global_protect_lock_bit));
endmodule // fosc_checker

bind fosc_overlay fosc_checker i_fosc_checker (.*);

// >>> sim/fosc_host.sv
module fosc_host (
  // Clock and returned data
  input wire logic clock,
  input wire logic [15:0] bus_rdata,
  // Requests
  output logic bus_wr,
  output logic bus_rd,
  output logic bus_burst_first,
  output logic [fosc_pkg::ADDR_W-1:0] bus_addr,
  output logic [15:0] bus_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial begin
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_burst_first = 1'b0;
    bus_addr = '0;
    bus_wdata = '0;
  end
  // Strobes stay up between calls so back-to-back requests never glitch
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    bus_rd = 1'b0;
    bus_burst_first = 1'b0;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clock);
    #1;
  endtask
  // Single-beat read, always the first beat, with the write strobe dropped
  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    bus_wr = 1'b0;
    bus_addr = a;
    bus_rd = 1'b1;
    bus_burst_first = 1'b1;
    @(posedge clock);
    #1;
    d = bus_rdata;
  endtask
  // Release the bus before idle clocks; inverted data is never trusted
  task automatic idle();
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_burst_first = 1'b0;
    bus_wdata = ~bus_wdata;
  endtask
endmodule // fosc_host

// >>> sim/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] cmd; logic [23:0] ra; logic [15:0] msk;
    logic [15:0] exp; logic [3:0] map; logic [15:0] ex;
  } fosc_row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic bus_wr, bus_rd, bus_first, crc_fetch, ssr_prog, lock;
  logic [23:0] bus_addr, crc_addr, prog_addr;
  logic [23:0] crc_start = 24'h000100;
  logic [15:0] bus_wdata, bus_rdata, prog_data, cfg, d, crc_data;
  logic [7:0] status = 8'h00;
  logic [3:0] map;
  logic [31:0] crc;
  logic [15:0] crc_in;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  fosc_row_t rows [8] = '{
    '{16'h0098, 24'h000010, 16'hffff, 16'hb010, 4'h1, 16'h00f0},
    '{16'h0088, 24'h000010, 16'hffff, 16'hc010, 4'h3, 16'h0090},
    '{16'h0088, 24'h000300, 16'hffff, 16'hffff, 4'h3, 16'h0000},
    '{16'h0088, 24'h040010, 16'hffff, 16'ha010, 4'h3, 16'h0090},
    '{16'h0040, 24'h000000, 16'hffff, 16'hffff, 4'h4, 16'h0000},
    '{16'h0040, 24'h000005, 16'hffff, 16'hffff, 4'h4, 16'h0090},
    '{16'h0060, 24'h000004, 16'hffff, 16'hffff, 4'h5, 16'h0000},
    '{16'h0050, 24'h7fffff, 16'h0001, 16'h0001, 4'h7, 16'h0090}};
  always #2.5 clock = ~clock;
  // Side stores tagged by source so a wrong mux choice shows
  // The CRC store answers while the fetch strobe stands
  assign crc_data = {4'hd, crc_addr[11:0]};
  fosc_host i_fosc_host (.clock(clock), .bus_rdata(bus_rdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_burst_first(bus_first),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  fosc_overlay i_fosc_overlay (.clock(clock), .rstn(rstn),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_burst_first(bus_first),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .array_rdata({4'ha, bus_addr[11:0]}),
    .query_rdata({4'hb, bus_addr[11:0]}),
    .ssr_rdata({4'hc, bus_addr[11:0]}), .device_status(status),
    .crc_start(crc_start), .crc_end(crc_start), .crc_fetch(crc_fetch),
    .crc_addr(crc_addr), .crc_fetch_data(crc_data), .ssr_prog(ssr_prog),
    .prog_addr(prog_addr), .prog_data(prog_data), .active_map(map),
    .global_protect_lock_bit(lock),
    .protection_configuration_register(cfg));
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] v);
    i_fosc_host.wr(a, v);
  endtask
  task automatic rd(input logic [23:0] a);
    i_fosc_host.rd(a, d);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard, far above the roughly one hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    // Expected check-value over the single word the store holds at start
    crc_in = {4'hd, crc_start[11:0]};
    crc = fosc_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      crc = {crc[30:0], 1'b0} ^
        ((crc[31] ^ crc_in[i]) ? fosc_pkg::CRC_POLY : 32'h0);
    repeat (16) @(posedge clock);
    #1;
    rstn = 1'b1;
    chk("reset map", 16'h0, {12'h0, map});
    chk("reset lock", 16'h1, {15'h0, lock});
    chk("reset cfg", fosc_pkg::CFG_RESET, cfg);
    foreach (rows[i]) begin
      wr(fosc_pkg::UNLOCK_ADDR, rows[i].cmd);
      rd(rows[i].ra);
      chk("row data", rows[i].exp, d & rows[i].msk);
      chk("row map", {12'h0, rows[i].map}, {12'h0, map});
      wr(fosc_pkg::EXIT_ADDR, rows[i].ex);
      chk("row exit", 16'h0, {12'h0, map});
    end
    status = 8'h5a;
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_SSR);
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_STATUS);
    status = 8'h00;
    rd(24'h0);
    chk("status", 16'h005a, d);
    chk("status back", 16'h3, {12'h0, map});
    wr(0, fosc_pkg::CMD_PROG);
    wr(24'h000020, 16'h55aa);
    chk("ssr prog", 16'h1, {15'h0, ssr_prog});
    chk("ssr addr", 16'h0020, prog_addr[15:0]);
    chk("ssr data", 16'h55aa, prog_data);
    wr(0, fosc_pkg::CMD_EXIT2);
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_CFG);
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_QUERY);
    chk("no nest", 16'h4, {12'h0, map});
    wr(0, fosc_pkg::CMD_PROG);
    wr(0, 16'h1234);
    rd(24'h0);
    chk("cfg prog", 16'h1234, d);
    wr(0, fosc_pkg::CMD_EXIT1);
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_LOCK);
    wr(0, fosc_pkg::CMD_PROG);
    wr(0, 16'h0000);
    chk("lock clear", 16'h0, {15'h0, lock});
    wr(0, fosc_pkg::CMD_EXIT2);
    // Mid-run reset sets the lock again so the unlock has work to do
    i_fosc_host.idle();
    rstn = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    rstn = 1'b1;
    chk("rerun map", 16'h0, {12'h0, map});
    chk("rerun lock", 16'h1, {15'h0, lock});
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_PWD);
    wr(0, fosc_pkg::CMD_PROG);
    wr(0, 16'h4321);
    rd(24'h0);
    chk("password", 16'h4321, d);
    wr(24'h001111, fosc_pkg::CMD_UNLOCK);
    chk("bad unlock", 16'h1, {15'h0, lock});
    wr(24'h004321, fosc_pkg::CMD_UNLOCK);
    chk("unlock", 16'h0, {15'h0, lock});
    wr(0, fosc_pkg::CMD_EXIT1);
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_PROT);
    wr(0, fosc_pkg::CMD_PROG);
    wr(24'h060000, 16'h0000);
    rd(24'h06abcd);
    chk("protect set", 16'h1, d & 16'h1);
    wr(0, fosc_pkg::CMD_BULK);
    rd(24'h06abcd);
    chk("protect erase", 16'h0, d & 16'h1);
    wr(0, fosc_pkg::CMD_RESET);
    chk("sw reset", 16'h0, {12'h0, map});
    wr(fosc_pkg::UNLOCK_ADDR, fosc_pkg::CMD_CRC);
    wr(0, fosc_pkg::CMD_CRC_START);
    i_fosc_host.idle();
    repeat (20) @(posedge clock);
    #1;
    rd(fosc_pkg::CRC_LO_ADDR);
    chk("crc low", crc[15:0], d);
    rd(fosc_pkg::CRC_HI_ADDR);
    chk("crc high", crc[31:16], d);
    wr(0, fosc_pkg::CMD_RESET);
    finish_test();
  end
endmodule // testbench
